// file: core/frpd_pkg.sv
// constants for the flash reset, power-down and id command block
package frpd_pkg;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET        = 8'h99;
	localparam logic [7:0] CMD_POWER_DOWN   = 8'hB9;
	localparam logic [7:0] CMD_RELEASE_ID   = 8'hAB;
	localparam logic [7:0] CMD_MAKER_ID     = 8'h90;
	localparam logic [7:0] CMD_DUAL_READ    = 8'hBB;
	localparam logic [7:0] CMD_QUAD_READ    = 8'hEB;
	localparam logic [7:0] CMD_WRAP_SET     = 8'h77;
	localparam logic [7:0] EXIT_BYTE        = 8'hFF;
	localparam logic [1:0] KEEP_CONTINUOUS  = 2'h2;
	localparam int         CONT_KEEP_HI     = 5;
	localparam int         CONT_EXIT_POS    = 4;
	localparam int         WRAP_DIS_POS     = 4;
	localparam logic [7:0] CONT_BITS_RESET  = 8'h10;
	localparam logic [7:0] WRAP_RESET       = 8'h10;
	// bit counts within a frame
	localparam int         INSTR_BITS       = 8;
	localparam int         DUAL_EXIT_BITS   = 16;
	localparam int         RES_ID_BITS      = 32;
	localparam int         MAKER_ADDR_BITS  = 32;
	localparam int         WRAP_BITS_END    = 40;
	localparam int         QUAD_MODE_END    = 16;
	localparam int         DUAL_MODE_END    = 20;
	// timing in ns and core clock period
	localparam int         CORE_PERIOD_NS   = 4;
	localparam int         DP_ENTRY_NS      = 3000;
	localparam int         RES1_NS          = 3000;
	localparam int         RES2_NS          = 1800;
	localparam int         RST_NS           = 30000;
	localparam int         DP_ENTRY_CYC     = DP_ENTRY_NS / CORE_PERIOD_NS;
	localparam int         RES1_CYC         = (RES1_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int         RES2_CYC         = (RES2_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int         RST_CYC          = (RST_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	typedef enum logic [1:0] {
		FRPD_NORMAL   = 2'b00,
		FRPD_ENTERING = 2'b01,
		FRPD_ASLEEP   = 2'b11,
		FRPD_WAKING   = 2'b10
	} frpd_power_t;
endpackage : frpd_pkg

// file: core/frpd_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module frpd_sync (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic din,
	output var  logic dout
);
	logic meta;
	// meta feeds only the second stage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : frpd_sync
`default_nettype wire

// file: core/frpd_timer.sv
// down counter that raises done after a loaded count
`timescale 1ns/1ps
`default_nettype none
module frpd_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output var  logic             busy,
	output logic                  done
);
	logic [WIDTH-1:0] left;
	initial begin
		if (WIDTH < 2) $error("frpd_timer width too small");
	end
	// load restarts the wait from the full count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= '0;
			busy <= 1'b0;
		end else if (load) begin
			left <= count;
			busy <= 1'b1;
		end else if (busy) begin
			left <= left - 1'b1;
			if (left == {{(WIDTH-1){1'b0}}, 1'b1}) busy <= 1'b0;
		end
	end
	assign done = busy && (left == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : frpd_timer
`default_nettype wire

// file: core/frpd_cmd.sv
// command interpreter for reset, continuous-read exit, power-down and id reads
`timescale 1ns/1ps
`default_nettype none
module frpd_cmd
	import frpd_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID    = 8'h5A, // arbitrary value
	parameter logic [7:0] MAKER_ID     = 8'hA5, // arbitrary value
	parameter int         RST_CYCLES   = RST_CYC,
	parameter int         RES1_CYCLES  = RES1_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       link_clk,
	input  wire logic       cs_n,
	input  wire logic       si,
	input  wire logic       op_busy,
	output logic            so,
	output logic            so_oe,
	output var  logic       deep_power_down_state,
	output var  logic       execute_in_place,
	output var  logic [7:0] continuous_read_bits,
	output var  logic       wrap_disable_bit,
	output logic            soft_reset_pulse,
	output logic            accepting
);
	initial begin
		if (RST_CYCLES < 1 || RST_CYCLES > 65535) $error("reset count out of range");
		if (RES1_CYCLES < 1 || RES1_CYCLES > 65535) $error("release count out of range");
	end

	// link domain: shift register and bit counter, cleared by chip select high
	logic [7:0]  shift;
	logic [5:0]  bit_cnt;
	logic [7:0]  instr;
	logic [23:0] addr;
	logic        cont_frame;
	logic        cont_quad;
	logic        cont_quad_core;
	logic        frame_tog;
	logic        exit_seen;
	logic [7:0]  frame_instr;
	logic [7:0]  mode_bits;
	logic        mode_valid;
	logic        id_seen;
	logic [5:0]  frame_bits;
	logic        asleep_link;
	logic        busy_link;
	logic        cont_link;
	logic [7:0]  next_shift;
	logic        shift_hi_ones;
	logic [7:0]  first_byte;
	logic [5:0]  bit_cnt_hold;
	logic        cont_quad_now;
	logic [7:0]  wrap_byte;
	assign next_shift = {shift[6:0], si};

	// mode flags captured into the link domain per frame; stable while cs_n is low
	always_ff @(negedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			asleep_link <= 1'b0;
			busy_link   <= 1'b0;
			cont_link   <= 1'b0;
			cont_quad   <= 1'b0;
		end else begin
			asleep_link <= deep_power_down_state;
			busy_link   <= op_busy;
			cont_link   <= execute_in_place;
			cont_quad   <= cont_quad_core;
		end
	end

	// bit collection on rising link clock, restarted by cs_n high
	always_ff @(posedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			shift   <= '0;
			bit_cnt <= '0;
		end else begin
			shift <= next_shift;
			if (bit_cnt != 6'h3F) bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// instruction, address and mode capture
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr      <= '0;
			addr       <= '0;
			mode_bits  <= CONT_BITS_RESET;
			mode_valid <= 1'b0;
			exit_seen  <= 1'b0;
			cont_frame <= 1'b0;
			wrap_byte  <= '0;
		end else begin
			if (bit_cnt == 6'h00) begin
				cont_frame <= cont_link;
				mode_valid <= 1'b0;
				exit_seen  <= 1'b0;
			end
			if (!cont_link && bit_cnt == 6'(INSTR_BITS - 1)) instr <= next_shift;
			if (bit_cnt >= 6'(INSTR_BITS) && bit_cnt < 6'(MAKER_ADDR_BITS))
				addr <= {addr[22:0], si};
			if (bit_cnt == 6'(WRAP_BITS_END - 1)) wrap_byte <= next_shift; // wrap bits follow the dummies
			// exit pattern: all ones for eight (quad) or sixteen (dual) clocks
			if (cont_link && bit_cnt == 6'(INSTR_BITS - 1) && next_shift == EXIT_BYTE && cont_quad)
				exit_seen <= 1'b1;
			if (cont_link && bit_cnt == 6'(DUAL_EXIT_BITS - 1) && next_shift == EXIT_BYTE
				&& shift_hi_ones && !cont_quad)
				exit_seen <= 1'b1;
			// continuous-mode byte, a simplified serial view of the mode cycles
			if ((instr == CMD_QUAD_READ || (cont_link && cont_quad)) && bit_cnt == 6'(QUAD_MODE_END - 1)) begin
				mode_bits  <= next_shift;
				mode_valid <= 1'b1;
			end
			if ((instr == CMD_DUAL_READ || (cont_link && !cont_quad)) && bit_cnt == 6'(DUAL_MODE_END - 1)) begin
				mode_bits  <= next_shift;
				mode_valid <= 1'b1;
			end
		end
	end
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) first_byte <= '0;
		else if (bit_cnt == 6'(INSTR_BITS - 1)) first_byte <= next_shift;
	end
	assign shift_hi_ones = (first_byte == EXIT_BYTE);

	// frame summary latched at cs_n rise and handed over by a toggle
	always_ff @(posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			frame_tog   <= 1'b0;
			frame_instr <= '0;
			frame_bits  <= '0;
			id_seen     <= 1'b0;
		end else begin
			frame_tog   <= ~frame_tog;
			frame_instr <= cont_frame ? 8'h00 : instr;
			frame_bits  <= bit_cnt_hold;
			id_seen     <= exit_seen;
		end
	end
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) bit_cnt_hold <= '0;
		else bit_cnt_hold <= (bit_cnt == 6'h3F) ? bit_cnt : bit_cnt + 6'h01;
	end

	// id output on falling link clock, msb first, repeated until cs_n rises
	logic [3:0] out_idx;
	logic [7:0] out_byte;
	logic       id_active;
	always_comb begin
		id_active = 1'b0;
		out_byte  = DEVICE_ID;
		if (instr == CMD_RELEASE_ID && bit_cnt >= 6'(RES_ID_BITS) && !cont_link && !busy_link) begin
			id_active = 1'b1;
			out_byte  = DEVICE_ID;
		end else if (instr == CMD_MAKER_ID && bit_cnt >= 6'(MAKER_ADDR_BITS) && !cont_link && !asleep_link) begin
			id_active = 1'b1;
			// address bit zero picks the first byte, then alternate
			out_byte  = (addr[0] ^ out_idx[3]) ? DEVICE_ID : MAKER_ID;
		end
	end
	// bytes counted from the first output bit; index wraps every two bytes
	always_ff @(negedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			out_idx <= '0;
			so      <= 1'b0;
			so_oe   <= 1'b0;
		end else if (id_active) begin
			so      <= out_byte[3'd7 - out_idx[2:0]];
			so_oe   <= 1'b1;
			out_idx <= out_idx + 4'h1;
		end
	end

	// core domain: frame event crossing
	logic frame_sync;
	logic frame_prev;
	logic frame_evt;
	frpd_sync u_frame_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.din      (frame_tog),
		.dout     (frame_sync)
	);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) frame_prev <= 1'b0;
		else frame_prev <= frame_sync;
	end
	assign frame_evt = frame_sync ^ frame_prev;

	// frame summary is stable long before the synchronised toggle arrives
	logic is_reset_en;
	logic is_reset;
	logic is_pd;
	logic is_release;
	logic is_res2;
	assign is_reset_en = frame_evt && frame_instr == CMD_RESET_ENABLE;
	assign is_reset    = frame_evt && frame_instr == CMD_RESET;
	assign is_pd       = frame_evt && frame_instr == CMD_POWER_DOWN && frame_bits == 6'(INSTR_BITS);
	assign is_release  = frame_evt && frame_instr == CMD_RELEASE_ID && frame_bits == 6'(INSTR_BITS);
	assign is_res2     = frame_evt && frame_instr == CMD_RELEASE_ID && frame_bits > 6'(INSTR_BITS);

	// power state machine with timers
	frpd_power_t pstate;
	logic        t_load;
	logic [15:0] t_count;
	logic        t_busy;
	logic        t_done;
	logic        rst_busy;
	logic        rst_done;
	frpd_timer #(.WIDTH(16)) u_power_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (t_load),
		.count    (t_count),
		.busy     (t_busy),
		.done     (t_done)
	);
	frpd_timer #(.WIDTH(16)) u_reset_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (soft_reset_pulse),
		.count    (16'(RST_CYCLES)),
		.busy     (rst_busy),
		.done     (rst_done)
	);
	always_comb begin
		t_load  = 1'b0;
		t_count = 16'(DP_ENTRY_CYC);
		if (pstate == FRPD_NORMAL && is_pd && !execute_in_place) begin
			t_load  = 1'b1;
			t_count = 16'(DP_ENTRY_CYC);
		end else if (pstate == FRPD_ASLEEP && (is_release || is_res2) && !op_busy) begin
			t_load  = 1'b1;
			t_count = is_res2 ? 16'(RES2_CYC) : 16'(RES1_CYCLES);
		end
	end
	// a new frame during the wake wait restarts nothing; host must keep cs_n high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pstate <= FRPD_NORMAL;
		end else begin
			case (pstate)
				FRPD_NORMAL:   if (t_load) pstate <= FRPD_ENTERING;
				FRPD_ENTERING: if (t_done) pstate <= FRPD_ASLEEP;
				FRPD_ASLEEP:   if (t_load) pstate <= FRPD_WAKING;
				FRPD_WAKING:   if (t_done) pstate <= FRPD_NORMAL;
				default:       pstate <= FRPD_NORMAL;
			endcase
		end
	end
	assign deep_power_down_state = (pstate == FRPD_ASLEEP) || (pstate == FRPD_WAKING);
	assign accepting = (pstate == FRPD_NORMAL) && !rst_busy;

	// reset arm: only the very next frame may be the reset
	logic reset_armed;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_armed <= 1'b0;
		end else if (frame_evt) begin
			reset_armed <= is_reset_en && pstate == FRPD_NORMAL && !execute_in_place;
		end
	end
	assign soft_reset_pulse = is_reset && reset_armed && pstate == FRPD_NORMAL && !execute_in_place;

	// continuous read mode and wrap configuration
	logic mode_sync;
	logic mode_prev;
	frpd_sync u_mode_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.din      (mode_valid),
		.dout     (mode_sync)
	);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) mode_prev <= 1'b0;
		else mode_prev <= mode_sync;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			continuous_read_bits <= CONT_BITS_RESET;
			cont_quad_core       <= 1'b0;
			wrap_disable_bit     <= WRAP_RESET[WRAP_DIS_POS];
		end else if (soft_reset_pulse) begin
			continuous_read_bits <= CONT_BITS_RESET;
			wrap_disable_bit     <= WRAP_RESET[WRAP_DIS_POS];
		end else if (frame_evt && id_seen) begin
			continuous_read_bits[CONT_EXIT_POS] <= 1'b1;
		end else if (frame_evt && mode_prev) begin
			// whole byte kept; only the keep field is decoded
			continuous_read_bits <= mode_bits;
			cont_quad_core       <= cont_quad_now;
		end else if (frame_evt && frame_instr == CMD_WRAP_SET && frame_bits >= 6'(WRAP_BITS_END)) begin
			wrap_disable_bit <= wrap_byte[WRAP_DIS_POS];
		end
	end
	assign cont_quad_now = (frame_instr == CMD_QUAD_READ) || (frame_instr == 8'h00 && cont_quad_core);
	// keep field 10 means no instruction byte next frame
	assign execute_in_place = (continuous_read_bits[CONT_KEEP_HI -: 2] == KEEP_CONTINUOUS);

	property p_reset_needs_arm;
		@(posedge core_clk) disable iff (!rst_n)
		soft_reset_pulse |-> $past(is_reset_en, 1) == 1'b0 && reset_armed;
	endproperty
	a_reset_needs_arm: assert property (p_reset_needs_arm) else $error("reset without enable");
	property p_no_reset_asleep;
		@(posedge core_clk) disable iff (!rst_n)
		deep_power_down_state |-> !soft_reset_pulse;
	endproperty
	a_no_reset_asleep: assert property (p_no_reset_asleep) else $error("reset while asleep");
	property p_sleep_entry;
		@(posedge core_clk) disable iff (!rst_n)
		(pstate == FRPD_NORMAL && t_load) |=> pstate == FRPD_ENTERING ##[1:750] pstate == FRPD_ASLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("power-down entry late");
	property p_disarm;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_evt && !is_reset_en) |=> !reset_armed;
	endproperty
	a_disarm: assert property (p_disarm) else $error("enable not dropped");
	property p_keep_field;
		@(posedge core_clk) disable iff (!rst_n)
		continuous_read_bits[5:4] != 2'h2 |-> !execute_in_place;
	endproperty
	a_keep_field: assert property (p_keep_field) else $error("continuous mode held");
	property p_exit;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_evt && id_seen && !soft_reset_pulse) |=> continuous_read_bits[4];
	endproperty
	a_exit: assert property (p_exit) else $error("exit bit not set");
	property p_busy_release;
		@(posedge core_clk) disable iff (!rst_n)
		(pstate == FRPD_ASLEEP && op_busy) |=> pstate == FRPD_ASLEEP;
	endproperty
	a_busy_release: assert property (p_busy_release) else $error("release while busy");
	property p_pd_length;
		@(posedge core_clk) disable iff (!rst_n)
		(frame_evt && frame_instr == CMD_POWER_DOWN && frame_bits != 6'h08) |=> pstate != FRPD_ENTERING || $past(pstate) == FRPD_ENTERING;
	endproperty
	a_pd_length: assert property (p_pd_length) else $error("bad power-down taken");
endmodule : frpd_cmd
`default_nettype wire

// file: tb/frpd_host.sv
// host controller model: spi mode 0 master that frames commands and reads id bits
`timescale 1ns/1ps
`default_nettype none
module frpd_host (
	output var  logic link_clk,
	output var  logic cs_n,
	output var  logic si,
	input  wire logic so,
	input  wire logic so_oe
);
	localparam int HALF_NS = 32; // 64 ns link clock period
	logic [63:0] rx;     // bits shifted back by the device
	logic        oe_any; // device drove so at some sample

	// idle bus: clock parked low, select high
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx = '0;
		oe_any = 1'b0;
	end

	// one frame: ntx bits out msb first, then nrx bits in, then select high
	task automatic frame(input logic [63:0] tx, input int ntx, input int nrx);
		rx = '0;
		oe_any = 1'b0;
		cs_n = 1'b0;
		for (int i = ntx - 1; i >= 0; i--) begin
			si = tx[i];
			#HALF_NS link_clk = 1'b1;
			#HALF_NS link_clk = 1'b0;
		end
		// released data line flips so a stale level is never mistaken for data
		si = ~si;
		for (int i = 0; i < nrx; i++) begin
			#HALF_NS link_clk = 1'b1;
			rx = {rx[62:0], so};
			oe_any = oe_any | so_oe;
			#HALF_NS link_clk = 1'b0;
		end
		// select rises half a period after the last falling clock edge, clock stays still
		#HALF_NS cs_n = 1'b1;
		#(2 * HALF_NS);
	endtask : frame
endmodule : frpd_host
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the reset, power-down and id command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import frpd_pkg::*;
	localparam logic [7:0] DEV_ID = 8'h5A; // arbitrary value
	localparam logic [7:0] MKR_ID = 8'hC3; // arbitrary value
	localparam int         SHORT  = 10;    // shortened reset and release counts
	logic       core_clk = 1'b0;
	logic       rst_n;
	logic       op_busy;
	logic       link_clk;
	logic       cs_n;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       deep_power_down_state;
	logic       execute_in_place;
	logic [7:0] continuous_read_bits;
	logic       wrap_disable_bit;
	logic       soft_reset_pulse;
	logic       accepting;
	int         errors = 0;
	int         cmp_count = 0;
	int         pulses = 0;
	int         p0;
	int         n;
	logic [7:0] keep_vals [3] = '{8'h00, 8'h10, 8'hF0};

	frpd_cmd #(.DEVICE_ID(DEV_ID), .MAKER_ID(MKR_ID), .RST_CYCLES(SHORT), .RES1_CYCLES(SHORT)) i_frpd_cmd (
		.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .cs_n(cs_n), .si(si),
		.op_busy(op_busy), .so(so), .so_oe(so_oe), .deep_power_down_state(deep_power_down_state),
		.execute_in_place(execute_in_place), .continuous_read_bits(continuous_read_bits),
		.wrap_disable_bit(wrap_disable_bit), .soft_reset_pulse(soft_reset_pulse), .accepting(accepting)
	);
	frpd_host i_frpd_host (.link_clk(link_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	// core clock and reset-pulse counter
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
	end

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : cmp_bit

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_word

	// frame, then let the toggle cross and the core outputs settle
	task automatic send(input logic [63:0] tx, input int ntx, input int nrx);
		i_frpd_host.frame(tx, ntx, nrx);
		repeat (8) @(posedge core_clk);
	endtask : send

	// bounded wait for the power state level, cycles waited in n
	task automatic wait_dpd(input logic lvl, input int lim);
		n = 0;
		while (deep_power_down_state !== lvl && n < lim) begin
			@(posedge core_clk);
			n++;
		end
	endtask : wait_dpd

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// hang guard at 300 us; the run needs about 53 us
	initial begin
		#300000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		op_busy = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		cmp_bit(deep_power_down_state, 1'b0, "asleep at power-up");
		cmp_bit(so_oe, 1'b0, "so driven at idle");
		cmp_bit(accepting, 1'b1, "not accepting at power-up");
		cmp_bit(wrap_disable_bit, 1'b1, "wrap default");
		cmp_word({24'h0, continuous_read_bits}, {24'h0, CONT_BITS_RESET}, "continuous default");
		$display("test defaults done");
		// warm-start sequence, then wrap on and a software reset
		send({48'h0, 16'hFFFF}, 16, 0);
		cmp_bit(continuous_read_bits[CONT_EXIT_POS], 1'b1, "exit bit after first frame");
		send({24'h0, CMD_WRAP_SET, 24'h0, WRAP_RESET}, 40, 0);
		cmp_bit(wrap_disable_bit, 1'b1, "wrap not disabled");
		send({24'h0, CMD_WRAP_SET, 32'h0}, 40, 0);
		cmp_bit(wrap_disable_bit, 1'b0, "wrap not enabled");
		p0 = pulses;
		send({56'h0, CMD_RESET_ENABLE}, 8, 0);
		send({56'h0, CMD_RESET}, 8, 0);
		cmp_word(pulses - p0, 32'h1, "reset pair pulses");
		cmp_bit(wrap_disable_bit, 1'b1, "wrap not reloaded");
		cmp_bit(accepting, 1'b1, "not accepting after reset time");
		$display("test reset pair done");
		// broken pair, id reads in between
		p0 = pulses;
		send({56'h0, CMD_RESET_ENABLE}, 8, 0);
		send({32'h0, CMD_MAKER_ID, 24'h0}, 32, 32);
		cmp_word(i_frpd_host.rx[31:0], {MKR_ID, DEV_ID, MKR_ID, DEV_ID}, "maker id order");
		send({56'h0, CMD_RESET}, 8, 0);
		cmp_word(pulses - p0, 32'h0, "disarmed reset ran");
		send({32'h0, CMD_MAKER_ID, 24'h1}, 32, 32);
		cmp_word(i_frpd_host.rx[31:0], {DEV_ID, MKR_ID, DEV_ID, MKR_ID}, "device first order");
		send({32'h0, CMD_RELEASE_ID, 24'h0}, 32, 24);
		cmp_word(i_frpd_host.rx[31:0], {8'h0, DEV_ID, DEV_ID, DEV_ID}, "repeated id");
		op_busy <= 1'b1;
		// busy must have settled before select falls
		@(posedge core_clk);
		send({32'h0, CMD_RELEASE_ID, 24'h0}, 32, 8);
		cmp_bit(i_frpd_host.oe_any, 1'b0, "id answered while busy");
		op_busy <= 1'b0;
		$display("test id reads done");
		// power-down: wrong length, entry time, refusals, release
		send({55'h0, CMD_POWER_DOWN, 1'b0}, 9, 0);
		wait_dpd(1'b1, 800);
		cmp_bit(deep_power_down_state, 1'b0, "nine-bit power-down ran");
		send({56'h0, CMD_POWER_DOWN}, 8, 0);
		wait_dpd(1'b1, 800);
		cmp_bit(n inside {[725:760]}, 1'b1, "power-down entry time");
		p0 = pulses;
		send({56'h0, CMD_RESET_ENABLE}, 8, 0);
		send({56'h0, CMD_RESET}, 8, 0);
		cmp_word(pulses - p0, 32'h0, "reset while asleep");
		send({32'h0, CMD_MAKER_ID, 24'h0}, 32, 16);
		cmp_bit(i_frpd_host.oe_any, 1'b0, "answered while asleep");
		send({56'h0, CMD_RELEASE_ID}, 8, 0);
		cmp_bit(deep_power_down_state, 1'b0, "not released");
		cmp_bit(accepting, 1'b1, "not accepting after release");
		send({56'h0, CMD_POWER_DOWN}, 8, 0);
		wait_dpd(1'b1, 800);
		send({32'h0, CMD_RELEASE_ID, 24'h0}, 32, 8);
		cmp_word({24'h0, i_frpd_host.rx[7:0]}, {24'h0, DEV_ID}, "id on release");
		cmp_bit(deep_power_down_state, 1'b1, "released before wait");
		wait_dpd(1'b0, 500);
		cmp_bit(n inside {[410:445]}, 1'b1, "release id wait time");
		$display("test power-down done");
		// continuous read entry and both exit patterns
		send({48'h0, CMD_QUAD_READ, 8'h20}, 16, 0);
		cmp_bit(execute_in_place, 1'b1, "quad keep field");
		cmp_word({24'h0, continuous_read_bits}, 32'h20, "quad mode bits");
		send({56'h0, EXIT_BYTE}, 8, 0);
		cmp_bit(execute_in_place, 1'b0, "quad exit");
		cmp_bit(continuous_read_bits[CONT_EXIT_POS], 1'b1, "exit bit after quad exit");
		send({44'h0, CMD_DUAL_READ, 4'h0, 8'hE5}, 20, 0);
		cmp_bit(execute_in_place, 1'b1, "reserved bits changed keep");
		send({48'h0, 16'hFFFF}, 16, 0);
		cmp_bit(execute_in_place, 1'b0, "dual exit");
		cmp_bit(continuous_read_bits[CONT_EXIT_POS], 1'b1, "exit bit after dual exit");
		for (int i = 0; i < 3; i++) begin
			send({48'h0, CMD_QUAD_READ, keep_vals[i]}, 16, 0);
			cmp_bit(execute_in_place, 1'b0, "other keep value kept mode");
		end
		$display("test continuous read done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
